// ===== hw/uboc_bit_timing.sv
/*
 bit-timing core: fractional prescaler, 16-bit divisor, programmable
 oversampling count, and isochronous 1x clocking per direction.
 assumes writes to the indexed set arrive as one-cycle strobes on clk_sys,
 and the modem control bit 7 and divisor bytes are held by the port.
*/
`timescale 1ns/100ps
`default_nettype none
// Function
// - ratio register sits at index 0x02
// - reset clears ratio to zero, sixteen
// - codes 0-3 give 16, else 4-15
// - upper four bits read as zero
// - writes 0x01, 0x10, 0x11 give sixteen
// - ratio one never enables isochronous mode
// - isochronous direction ignores ratio setting
// - read returns last written low nibble
// - ratio works without any enhanced mode
// - external bit clocks on ring, dsr pins
// - clock-select bits 7,3 enable isochronous
// - isochronous keeps framing, bit per clock
// - one bit clock equals one bit
// - rate is clock over sc*div*prescale
// - sixteen-bit divisor from two bytes
// - prescale is M plus N eighths
// - modem bit 7 low bypasses prescaler
module uboc_bit_timing
   import uboc_pkg::*;
(
   input wire logic clk_sys, // 40 MHz system clock
   input wire logic rst_b, // async reset, active low
   input wire uboc_wr_t host_wr, // indexed write strobe
   input wire logic [7:0] rd_idx, // indexed read select
   output logic [7:0] rd_data, // indexed read data
   input wire logic [15:0] divisor, // high and low divisor bytes
   input wire logic prescale_en, // modem control bit 7
   input wire logic ring_clk_b_pin, // external tx bit clock
   input wire logic dsr_clk_b_pin, // external rx bit clock
   input wire logic rx_line, // serial input from the pin
   input wire logic rx_start, // start edge seen by receiver
   output uboc_tick_t tick // bit and sample ticks
);
   logic [7:0] ratio_q; // oversample_ratio, full byte kept
   logic [7:0] prescale_q; // prescale_reg
   logic [7:0] clksel_q; // clock_select_reg
   logic [1:0] ri_sync_q, dsr_sync_q; // pin synchronisers
   logic ri_d1_q, dsr_d1_q; // edge history after sync
   logic [4:0] sc; // decoded sample cycles per bit
   logic [8:0] pre_acc_q; // prescaler in eighths
   logic pre_tick; // prescaled clock enable
   logic [15:0] div_cnt_q; // divisor counter
   logic div_tick; // sample clock enable
   logic [4:0] tx_cnt_q, rx_cnt_q; // oversample counters
   logic tx_iso, rx_iso; // direction in 1x mode
   logic ri_rise, dsr_rise; // external clock edges
   logic tx_os_tick, rx_os_tick; // oversampled ticks
   logic [8:0] pre_step; // M + N/8 in eighths

   // register writes, no enhanced-mode gate on the ratio
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ratio_q <= UBOC_RATIO_RST;
         prescale_q <= UBOC_PRESCALE_RST;
         clksel_q <= UBOC_CLKSEL_RST;
      end
      else if (host_wr.wr)
      begin
         case (host_wr.idx)
            UBOC_IDX_RATIO: ratio_q <= host_wr.wdata;
            UBOC_IDX_PRESCALE: prescale_q <= host_wr.wdata;
            UBOC_IDX_CLKSEL: clksel_q <= host_wr.wdata;
            default: ;
         endcase
      end
   end

   // read mux; upper ratio nibble reads zero in every mode
   always_comb
   begin
      case (rd_idx)
         UBOC_IDX_RATIO: rd_data = {4'h0, ratio_q[3:0]};
         UBOC_IDX_PRESCALE: rd_data = prescale_q;
         UBOC_IDX_CLKSEL: rd_data = clksel_q;
         default: rd_data = 8'h00;
      endcase
   end

   // only the low nibble matters, so 0x10 and 0x11 act like 0x00, 0x01
   always_comb
   begin
      if (ratio_q[3:0] < UBOC_SC_MIN_CODE)
         sc = UBOC_SC_DEFAULT;
      else
         sc = {1'b0, ratio_q[3:0]};
   end

   // isochronous comes only from the clock-select bits
   assign tx_iso = clksel_q[UBOC_CKS_TX_ISO_BIT];
   assign rx_iso = clksel_q[UBOC_CKS_RX_ISO_BIT];

   // fractional prescaler: accumulate 8 per clock, tick when step reached.
   // the remainder carries over, so the average is exact at the cost of jitter
   assign pre_step = {1'b0, prescale_q[7:3], 3'b000} + {6'h00, prescale_q[2:0]};
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         pre_acc_q <= 9'h000;
      else if (!prescale_en || pre_step < 9'h008)
         pre_acc_q <= 9'h000; // bypass or M of zero
      else if (pre_acc_q + 9'h008 >= pre_step)
         pre_acc_q <= pre_acc_q + 9'h008 - pre_step;
      else
         pre_acc_q <= pre_acc_q + 9'h008;
   end
   assign pre_tick = !prescale_en || pre_step < 9'h008 ||
                     (pre_acc_q + 9'h008 >= pre_step);

   // divisor counter; a zero divisor behaves as one
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         div_cnt_q <= 16'h0000;
      else if (pre_tick)
      begin
         if (div_cnt_q + 16'h0001 >= divisor)
            div_cnt_q <= 16'h0000;
         else
            div_cnt_q <= div_cnt_q + 16'h0001;
      end
   end
   assign div_tick = pre_tick && (div_cnt_q + 16'h0001 >= divisor);

   // two-stage synchronisers for the external bit clocks
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ri_sync_q <= 2'b11;
         dsr_sync_q <= 2'b11;
         ri_d1_q <= 1'b1;
         dsr_d1_q <= 1'b1;
      end
      else
      begin
         ri_sync_q <= {ri_sync_q[0], ring_clk_b_pin};
         dsr_sync_q <= {dsr_sync_q[0], dsr_clk_b_pin};
         ri_d1_q <= ri_sync_q[1];
         dsr_d1_q <= dsr_sync_q[1];
      end
   end
   // one rising edge of the 1x clock is one serial bit; sync limits rate
   assign ri_rise = ri_sync_q[1] && !ri_d1_q;
   assign dsr_rise = dsr_sync_q[1] && !dsr_d1_q;

   // transmit oversample counter: bit tick when count reaches sc
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         tx_cnt_q <= 5'h00;
      else if (tx_iso)
         tx_cnt_q <= 5'h00;
      else if (div_tick)
      begin
         if (tx_cnt_q + 5'h01 >= sc)
            tx_cnt_q <= 5'h00;
         else
            tx_cnt_q <= tx_cnt_q + 5'h01;
      end
   end
   assign tx_os_tick = div_tick && (tx_cnt_q + 5'h01 >= sc);

   // receive counter restarts on the start edge, samples at half count
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         rx_cnt_q <= 5'h00;
      else if (rx_iso || rx_start)
         rx_cnt_q <= 5'h00;
      else if (div_tick)
      begin
         if (rx_cnt_q + 5'h01 >= sc)
            rx_cnt_q <= 5'h00;
         else
            rx_cnt_q <= rx_cnt_q + 5'h01;
      end
   end
   assign rx_os_tick = div_tick && (rx_cnt_q == {1'b0, sc[4:1]} - 5'h01);

   // ticks registered; framing stays in the shifters, unchanged in 1x mode
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         tick <= '0;
      else
      begin
         tick.tx_bit <= tx_iso ? ri_rise : tx_os_tick;
         tick.rx_sample <= rx_iso ? dsr_rise : rx_os_tick;
      end
   end

   // rx_line is consumed by the shifter; not read here
   logic unused_rx;
   assign unused_rx = rx_line;

   // checks
   property p_ratio_reset;
      @(posedge clk_sys) $rose(rst_b) |-> ratio_q == UBOC_RATIO_RST;
   endproperty
   a_ratio_reset: assert property (p_ratio_reset) else $error("ratio not reset");
   property p_upper_zero;
      @(posedge clk_sys) disable iff (!rst_b)
         rd_idx == UBOC_IDX_RATIO |-> rd_data[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("ratio upper nibble");
   property p_readback;
      @(posedge clk_sys) disable iff (!rst_b)
         host_wr.wr && host_wr.idx == UBOC_IDX_RATIO ##1 rd_idx == UBOC_IDX_RATIO
         |-> rd_data[3:0] == $past(host_wr.wdata[3:0]);
   endproperty
   a_readback: assert property (p_readback) else $error("ratio readback");
   property p_decode;
      @(posedge clk_sys) disable iff (!rst_b)
         sc == (ratio_q[3:2] == 2'b00 ? 5'd16 : {1'b0, ratio_q[3:0]});
   endproperty
   a_decode: assert property (p_decode) else $error("sample decode");
   // without the select bit the tx tick must come from the oversample count,
   // whatever ratio value was written, one included
   property p_no_iso_from_ratio;
      @(posedge clk_sys) disable iff (!rst_b)
         !clksel_q[UBOC_CKS_TX_ISO_BIT] |=> tick.tx_bit == $past(tx_os_tick);
   endproperty
   a_no_iso_from_ratio: assert property (p_no_iso_from_ratio) else $error("iso leak");
   // in 1x mode the tx tick only follows a synchronised pin edge
   property p_tx_iso_only_edge;
      @(posedge clk_sys) disable iff (!rst_b)
         tx_iso && !ri_rise |=> !tick.tx_bit;
   endproperty
   a_tx_iso_only_edge: assert property (p_tx_iso_only_edge) else $error("tx 1x extra");
   property p_rx_iso_tick;
      @(posedge clk_sys) disable iff (!rst_b)
         rx_iso && dsr_rise |=> tick.rx_sample;
   endproperty
   a_rx_iso_tick: assert property (p_rx_iso_tick) else $error("rx 1x tick lost");
   // a start edge restarts the receive count so sampling is mid-bit
   property p_rx_restart;
      @(posedge clk_sys) disable iff (!rst_b)
         rx_start |=> rx_cnt_q == 5'h00;
   endproperty
   a_rx_restart: assert property (p_rx_restart) else $error("rx count not restarted");
   // a ratio write lands in the register at the next edge
   property p_ratio_write;
      @(posedge clk_sys) disable iff (!rst_b)
         host_wr.wr && host_wr.idx == UBOC_IDX_RATIO |=> ratio_q == $past(host_wr.wdata);
   endproperty
   a_ratio_write: assert property (p_ratio_write) else $error("ratio write lost");
   // writes to other indices leave the ratio alone
   property p_ratio_other_idx;
      @(posedge clk_sys) disable iff (!rst_b)
         host_wr.wr && host_wr.idx != UBOC_IDX_RATIO |=> $stable(ratio_q);
   endproperty
   a_ratio_other_idx: assert property (p_ratio_other_idx) else $error("ratio hit");
   // the divisor count stays below the divisor once it is there
   property p_div_bound;
      @(posedge clk_sys) disable iff (!rst_b)
         $stable(divisor) && $past(div_cnt_q) < $past(divisor) |-> div_cnt_q < divisor;
   endproperty
   a_div_bound: assert property (p_div_bound) else $error("divisor count");
   // the eighths accumulator never reaches the step while prescaling
   property p_pre_bound;
      @(posedge clk_sys) disable iff (!rst_b)
         prescale_en && $stable(prescale_q) && pre_step >= 9'h008 &&
         $past(pre_acc_q) < $past(pre_step) |-> pre_acc_q < pre_step;
   endproperty
   a_pre_bound: assert property (p_pre_bound) else $error("prescale accumulator");
   property p_tx_iso_tick;
      @(posedge clk_sys) disable iff (!rst_b)
         tx_iso && ri_rise |=> tick.tx_bit;
   endproperty
   a_tx_iso_tick: assert property (p_tx_iso_tick) else $error("tx 1x tick lost");
   property p_rx_iso_only_edge;
      @(posedge clk_sys) disable iff (!rst_b)
         rx_iso && !dsr_rise |=> !tick.rx_sample;
   endproperty
   a_rx_iso_only_edge: assert property (p_rx_iso_only_edge) else $error("rx 1x extra");
   property p_bypass;
      @(posedge clk_sys) disable iff (!rst_b) !prescale_en |-> pre_tick;
   endproperty
   a_bypass: assert property (p_bypass) else $error("prescale not bypassed");
   property p_tx_count_bound;
      @(posedge clk_sys) disable iff (!rst_b)
         $stable(ratio_q) && $past(tx_cnt_q) < $past(sc) |-> tx_cnt_q < sc;
   endproperty
   a_tx_count_bound: assert property (p_tx_count_bound) else $error("tx count");
   // main scenarios: 1x tx, mid-bit rx sample, shortest count, fractional step
   c_tx_iso: cover property (@(posedge clk_sys) tx_iso && tick.tx_bit);
   c_rx_mid: cover property (@(posedge clk_sys) !rx_iso && tick.rx_sample);
   c_sc4: cover property (@(posedge clk_sys) sc == 5'd4 && tx_os_tick);
   c_frac: cover property (@(posedge clk_sys) prescale_en && prescale_q[2:0] != 3'h0 && pre_tick);
endmodule : uboc_bit_timing
`default_nettype wire

// ===== hw/uboc_pkg.sv
/*
 package for the serial port bit-timing block: indexed register offsets,
 field positions, reset values and shared types.
 assumes a single 40 MHz system clock domain.
*/
package uboc_pkg;
   // indexed control set offsets
   localparam logic [7:0] UBOC_IDX_PRESCALE = 8'h01;
   localparam logic [7:0] UBOC_IDX_RATIO = 8'h02;
   localparam logic [7:0] UBOC_IDX_CLKSEL = 8'h03;
   // reset values
   localparam logic [7:0] UBOC_RATIO_RST = 8'h00;
   localparam logic [7:0] UBOC_PRESCALE_RST = 8'h20;
   localparam logic [7:0] UBOC_CLKSEL_RST = 8'h00;
   localparam logic [15:0] UBOC_DIVISOR_RST = 16'h0001;
   // field positions
   localparam int UBOC_CKS_TX_ISO_BIT = 7;
   localparam int UBOC_CKS_RX_ISO_BIT = 3;
   localparam int UBOC_MCR_PRESCALE_BIT = 7;
   // sample-count limits
   localparam logic [4:0] UBOC_SC_DEFAULT = 5'h10;
   localparam logic [3:0] UBOC_SC_MIN_CODE = 4'h4;
   // host write strobe and data, one cycle
   typedef struct packed {
      logic wr;
      logic [7:0] idx;
      logic [7:0] wdata;
   } uboc_wr_t;
   // tick outputs toward the shift logic
   typedef struct packed {
      logic tx_bit;
      logic rx_sample;
   } uboc_tick_t;
endpackage : uboc_pkg

// ===== tb/uboc_remote_clk.sv
/*
 remote transceiver model: supplies the external 1x bit clocks on the
 ring and dsr pins. assumes the bench raises run for the length of a frame.
*/
`timescale 1ns/100ps
`default_nettype none
module uboc_remote_clk #(
   parameter int HALF_NS = 100 // half bit period, 8 system cycles a bit
)
(
   input wire logic run, // frame in progress
   output logic ring_clk_b, // tx bit clock toward the device
   output logic dsr_clk_b // rx bit clock toward the device
);
   // both clocks idle high and toggle only inside a frame
   initial
   begin
      ring_clk_b = 1'b1;
      dsr_clk_b = 1'b1;
      forever
      begin
         wait (run);
         // one full clock cycle stands for one serial bit
         #HALF_NS {ring_clk_b, dsr_clk_b} = 2'b00;
         #HALF_NS {ring_clk_b, dsr_clk_b} = 2'b11;
      end
   end
endmodule : uboc_remote_clk
`default_nettype wire

// ===== tb/uboc_bit_timing_tb.sv
/*
 self-checking bench for the bit-timing core: register access, tick
 spacing per ratio, prescaler and isochronous clocking.
 assumes the design's ticks are one-cycle registered pulses.
*/
`timescale 1ns/100ps
`default_nettype none
module uboc_bit_timing_tb;
   import uboc_pkg::*;
   logic clk_sys = 1'b0, rst_b = 1'b0, prescale_en, rx_line, rx_start, run, ring_b, dsr_b;
   uboc_wr_t host_wr; // write strobe toward the device
   logic [7:0] rd_idx, rd_data;
   logic [15:0] divisor;
   uboc_tick_t tick;
   int num_errors = 0, n_tests = 0, n;
   logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h03, 8'h04, 8'h09, 8'h0f};

   // 40 MHz system clock
   always #12.5 clk_sys = ~clk_sys;

   uboc_bit_timing i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .host_wr(host_wr),
      .rd_idx(rd_idx), .rd_data(rd_data), .divisor(divisor), .prescale_en(prescale_en),
      .ring_clk_b_pin(ring_b), .dsr_clk_b_pin(dsr_b), .rx_line(rx_line),
      .rx_start(rx_start), .tick(tick));
   uboc_remote_clk i_far (.run(run), .ring_clk_b(ring_b), .dsr_clk_b(dsr_b));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one-cycle write strobe, launched just after an edge; an idle edge
   // follows so a second call never re-raises the strobe in the same step
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      host_wr = '{wr: 1'b1, idx: idx, wdata: d};
      @(posedge clk_sys);
      #1 host_wr.wr = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : wr

   // read is combinational; let the select settle before comparing
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      rd_idx = idx;
      #2 chk({8'h00, rd_data}, {8'h00, exp});
   endtask : rd

   // cycles between two ticks; the first interval is skipped as it may
   // still run on the old setting
   task automatic period(input logic rx, output int cnt);
      int k;
      k = 0;
      repeat (2)
      begin
         cnt = 0;
         do
         begin
            @(posedge clk_sys);
            #1 cnt++;
         end while ((rx ? tick.rx_sample : tick.tx_bit) !== 1'b1 && cnt < 3000);
      end
   endtask : period

   task automatic print_verdict;
      $display("errors %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // watchdog, far beyond the expected run of several hundred cycles
   initial
   begin
      #500us num_errors++;
      print_verdict();
   end

   initial
   begin
      host_wr = '0;
      rd_idx = 8'h00;
      divisor = 16'h0002;
      prescale_en = 1'b0;
      rx_line = 1'b1;
      rx_start = 1'b0;
      run = 1'b0;
      repeat (20) @(posedge clk_sys);
      #1 rst_b = 1'b1;
      @(posedge clk_sys);
      #1 rd(UBOC_IDX_RATIO, 8'h00);
      rd(UBOC_IDX_PRESCALE, UBOC_PRESCALE_RST);
      rd(UBOC_IDX_CLKSEL, 8'h00);
      wr(UBOC_IDX_RATIO, 8'hfa);
      rd(UBOC_IDX_RATIO, 8'h0a);
      wr(8'h07, 8'h05);
      rd(UBOC_IDX_RATIO, 8'h0a);
      // every ratio class, divisor two, prescaler bypassed
      foreach (codes[i])
      begin
         wr(UBOC_IDX_RATIO, codes[i]);
         period(1'b0, n);
         chk(16'(n), (codes[i][3:0] < 4'h4) ? 16'h0020 : 16'(2 * codes[i][3:0]));
      end
      // receiver counts from its start edge at the same rate
      rx_start = 1'b1;
      @(posedge clk_sys);
      #1 rx_start = 1'b0;
      period(1'b1, n);
      chk(16'(n), 16'h001e);
      // prescaler M=2 doubles the bit time, bypassed when enable drops
      wr(UBOC_IDX_RATIO, 8'h04);
      wr(UBOC_IDX_PRESCALE, 8'h10);
      prescale_en = 1'b1;
      period(1'b0, n);
      chk(16'(n), 16'h0010);
      prescale_en = 1'b0;
      period(1'b0, n);
      chk(16'(n), 16'h0008);
      // isochronous both ways: bit time follows the far clock only
      wr(UBOC_IDX_CLKSEL, 8'h88);
      wr(UBOC_IDX_RATIO, 8'h05);
      run = 1'b1;
      period(1'b0, n);
      chk(16'(n), 16'h0008);
      period(1'b1, n);
      chk(16'(n), 16'h0008);
      rd(UBOC_IDX_RATIO, 8'h05);
      run = 1'b0;
      print_verdict();
   end
endmodule : uboc_bit_timing_tb
`default_nettype wire
